// [shared/cmf_pkg.sv]
// Purpose: Constants and carrier types of the charger mode and fault supervisor
// Assumes: 100 MHz core clock; comparator decisions arrive as asynchronous levels
// Notes:   Long counts are also top-level parameters so a simulation can shorten them
// Contract
// R1 - Qualified short switches discharge path off
// R2 - Retry after recovery until short clears
// R3 - Short deglitch is 250 us
// R4 - Short recovery off-time is 2 s
// R5 - Low cutoff opens path, 150 mV rearm
// R6 - Battery only: path on, rail later
// R7 - Input arrives: supplement and discharge on; idle mode keeps both off
// R8 - Pin or enable bit disables charging
// R9 - Resume needs input, pin low, enabled
// R10 - Host interfaces ready 5 ms after rail
// R11 - Measure battery before entering high impedance
// R12 - Trigger measures, result within 2 ms
// R13 - Result in 2% steps, 60 to 100%
// R14 - Sleep entry: path on, pulse, fault
// R15 - Leaving sleep starts new charge cycle
// R16 - Sleep fault holds until read and ended
// R17 - Floor 4.2 to 4.9 V, or off
// R18 - Floor limiting: flag, no termination, slow timer
// R19 - Overvoltage: path on, pulse, then recover
// R20 - Overvoltage fault clears on read after end
// R21 - Qualified undervoltage: pulse and fault bits
// R22 - Enable bit one holds charge off
// R23 - Terminate in CV at taper above recharge
// R24 - No termination outside constant voltage
// R25 - Pulse counted in cycles, never shortened
package cmf_pkg;

    // Clock and times in their own units
    localparam int CLK_MHZ      = 100;
    localparam int T_SC_DGL_US  = 250;
    localparam int T_SC_REC_S   = 2;
    localparam int T_PULSE_US   = 128;
    localparam int T_READY_MS   = 5;
    localparam int T_MEAS_MS    = 2;
    localparam int T_DGL_US     = 100;

    // Derived cycle counts
    localparam int SC_DGL_CYC   = T_SC_DGL_US * CLK_MHZ;
    localparam int SC_REC_CYC   = T_SC_REC_S * 1000000 * CLK_MHZ;
    localparam int PULSE_CYC    = T_PULSE_US * CLK_MHZ;
    localparam int READY_CYC    = T_READY_MS * 1000 * CLK_MHZ;
    localparam int MEAS_CYC     = T_MEAS_MS * 1000 * CLK_MHZ;
    localparam int DGL_CYC      = T_DGL_US * CLK_MHZ;

    // Voltage settings in mV
    localparam logic [12:0] FLOOR_BASE_MV = 13'd4200;
    localparam logic [12:0] FLOOR_STEP_MV = 13'd100;
    localparam logic [12:0] REARM_HYST_MV = 13'd150;

    // Battery level comparator taps: 60% to 100% in 2% steps
    localparam int          LVL_TAPS      = 21;
    localparam logic [4:0]  LVL_RESET     = 5'h00;

    // Operating modes
    typedef enum logic [2:0] {
        M_HIZ    = 3'b000,
        M_ACTBAT = 3'b001,
        M_SLEEP  = 3'b010,
        M_IDLE   = 3'b011,
        M_CHARGE = 3'b100,
        M_DONE   = 3'b101,
        M_OVP    = 3'b110,
        M_MEAS   = 3'b111
    } cmf_mode_e;

    // Comparator and pin decisions, all asynchronous
    typedef struct packed {
        logic                vin_input_undervoltage_ok;
        logic                vin_above_sleep;
        logic                vin_ovp;
        logic                vin_at_floor;
        logic                bat_above_cutoff;
        logic                bat_above_rearm;
        logic                bat_above_min;
        logic                short_hit;
        logic                rail_ok;
        logic                cv_loop;
        logic                other_loop;
        logic                taper_reached;
        logic                bat_above_recharge;
        logic                charge_inhibit_pin_n;
        logic [LVL_TAPS-1:0] level_taps;
    } cmf_cmp_s;

    // Latched fault bits seen by the host
    typedef struct packed {
        logic sleep;
        logic input_overvoltage;
        logic input_undervoltage;
    } cmf_fault_s;

endpackage

// [src/cmf_sync3.sv]
// Purpose: Three-stage synchroniser for a vector of asynchronous levels
// Assumes: Single core clock, synchronous active-high reset
// Notes:   A bit changes only once stages two and three agree
`timescale 1ns/1ps
module cmf_sync3 #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             reset_in,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1;  // First stage, read only by s2
    logic [WIDTH-1:0] s2;  // Second stage
    logic [WIDTH-1:0] s3;  // Third stage

    // Shift chain
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Accept a bit only where the last two stages agree
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sync_out <= '0;
        end else begin
            sync_out <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & sync_out);
        end
    end
endmodule // cmf_sync3

// [src/cmf_pulse.sv]
// Purpose: Fixed-width active pulse for the open-drain event line
// Assumes: Width given in core clock cycles
// Notes:   Triggers during a pulse are absorbed
`timescale 1ns/1ps
module cmf_pulse #(
    parameter int WIDTH_CYC = 12800
) (
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic reset_in,
    // Event in, pulse out
    input  wire logic trig_in,
    output logic      busy_out
);
    logic [15:0] cnt;  // Cycles into the pulse

    // Count out the pulse, ignoring new events meanwhile
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            busy_out <= 1'b0;
            cnt      <= 16'h0000;
        end else if (busy_out) begin
            if (cnt == 16'(WIDTH_CYC - 1)) begin  // R25
                busy_out <= 1'b0;
                cnt      <= 16'h0000;
            end else begin
                cnt <= cnt + 16'h0001;
            end
        end else if (trig_in) begin
            busy_out <= 1'b1;
        end
    end

    a_pulse_width: assert property (@(posedge core_clk_in) disable iff (reset_in) // R25
        $fell(busy_out) |-> $past(cnt) == 16'(WIDTH_CYC - 1))
        else $error("event pulse width wrong");
endmodule // cmf_pulse

// [src/cmf_top.sv]
// Purpose: Mode selection, short retry, fault flags and level sampling of the charger
// Assumes: Comparator decisions are asynchronous; host bits are core-clock levels
// Notes:   Analog loops stay outside; this block only decides and reports
`timescale 1ns/1ps
module cmf_top
    import cmf_pkg::*;
#(
    parameter int SC_DGL = SC_DGL_CYC,
    parameter int SC_REC = SC_REC_CYC,
    parameter int PULSE  = PULSE_CYC,
    parameter int READY  = READY_CYC,
    parameter int MEAS   = MEAS_CYC,
    parameter int DGL    = DGL_CYC
) (
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        reset_in,
    // Analog decisions and the inhibit pin
    input  wire cmf_cmp_s    cmp_in,
    // Host control bits
    input  wire logic        charge_enable_n_in,
    input  wire logic        term_enable_in,
    input  wire logic        double_timer_in,
    input  wire logic [2:0]  input_voltage_floor_in,
    input  wire logic        floor_disable_in,
    input  wire logic [12:0] battery_low_cutoff_in,
    input  wire logic        level_sample_trigger_in,
    input  wire logic        fault_read_in,
    // Switch, rail and threshold controls
    output logic             disch_on_out,
    output logic             supplement_on_out,
    output logic             charge_switch_on_out,
    output logic             rail_enable_out,
    output logic [12:0]      floor_mv_out,
    output logic [12:0]      rearm_mv_out,
    // Status to host
    output cmf_mode_e        mode_out,
    output cmf_fault_s       fault_out,
    output logic             input_droop_flag_out,
    output logic             timer_half_speed_out,
    output logic [4:0]       level_threshold_result_out,
    output logic             level_busy_out,
    output logic             host_ready_out,
    // Open-drain event line
    output logic             event_o_out,
    output logic             event_oe_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    cmf_cmp_s    cmp;          // Synchronised decisions
    cmf_mode_e   mode;         // Current mode
    cmf_mode_e   next_mode;    // Mode for next cycle
    logic [27:0] sc_cnt;       // Short deglitch / recovery count
    logic        sc_off;       // Discharge path held off by short
    logic        bat_ok;       // Battery above cutoff with hysteresis
    logic [15:0] gone_cnt;     // Undervoltage deglitch count
    logic        input_gone;   // Qualified input absence
    logic [15:0] ovp_cnt;      // Overvoltage release count
    logic        ovp_act;      // Overvoltage in force
    logic [15:0] rail_cnt;     // Rail bring-up delay
    logic [27:0] rdy_cnt;      // Host interface ready delay
    logic [27:0] meas_cnt;     // Measurement window count
    logic        meas_busy;    // Measurement running
    logic        meas_done;    // Result latched this cycle
    logic        sleep_seen;   // Sleep fault read by host
    logic        droop;        // Floor limiting active
    logic        charge_go;    // Charging permitted
    logic        term_hit;     // Termination condition
    logic        sleep_evt;    // Entering sleep
    logic        ovp_evt;      // Overvoltage onset
    logic        input_undervoltage_evt;     // Undervoltage qualified
    logic        ev_busy;      // Event pulse in progress

    // Count comparator taps that the battery exceeds
    function automatic logic [4:0] tap_code(input logic [LVL_TAPS-1:0] taps);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < LVL_TAPS; i++) begin
            n = n + {4'h0, taps[i]};
        end
        return n;
    endfunction

    // Bring all pin and comparator levels into the clock domain
    cmf_sync3 #(.WIDTH($bits(cmf_cmp_s))) u_sync (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .async_in    (cmp_in),
        .sync_out    (cmp)
    );

    // Single event pulse generator shared by all faults
    cmf_pulse #(.WIDTH_CYC(PULSE)) u_pulse (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .trig_in     (sleep_evt | ovp_evt | input_undervoltage_evt),  // R14 R19 R21
        .busy_out    (ev_busy)
    );

    // Derived conditions
    assign droop     = cmp.vin_at_floor & ~floor_disable_in & ~input_gone;  // R18
    assign charge_go = ~cmp.charge_inhibit_pin_n & ~charge_enable_n_in;     // R8 R9 R22
    assign term_hit  = term_enable_in & cmp.cv_loop & ~cmp.other_loop       // R23 R24
                     & ~droop & cmp.taper_reached & cmp.bat_above_recharge; // R18
    assign sleep_evt = (mode != M_SLEEP) && (next_mode == M_SLEEP);         // R14
    assign meas_done = meas_busy && (meas_cnt == 28'(MEAS - 1));            // R12

    // Short-circuit deglitch, off-time and retry
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sc_cnt <= 28'h0000000;
            sc_off <= 1'b0;
        end else if (sc_off) begin
            // Hold off, then switch back on to retest
            if (sc_cnt == 28'(SC_REC - 1)) begin  // R2 R4
                sc_off <= 1'b0;
                sc_cnt <= 28'h0000000;
            end else begin
                sc_cnt <= sc_cnt + 28'h0000001;
            end
        end else if (cmp.short_hit) begin
            // Short must persist for the deglitch time
            if (sc_cnt == 28'(SC_DGL - 1)) begin  // R1 R3
                sc_off <= 1'b1;
                sc_cnt <= 28'h0000000;
            end else begin
                sc_cnt <= sc_cnt + 28'h0000001;
            end
        end else begin
            sc_cnt <= 28'h0000000;
        end
    end

    // Battery cutoff with rearm comparator above it
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            bat_ok <= 1'b0;
        end else if (!cmp.bat_above_cutoff) begin
            bat_ok <= 1'b0;  // R5
        end else if (cmp.bat_above_rearm) begin
            bat_ok <= 1'b1;  // R5
        end
    end

    // Undervoltage qualification
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            gone_cnt   <= 16'h0000;
            input_gone <= 1'b1;
            input_undervoltage_evt   <= 1'b0;
        end else if (cmp.vin_input_undervoltage_ok) begin
            gone_cnt   <= 16'h0000;
            input_gone <= 1'b0;
            input_undervoltage_evt   <= 1'b0;
        end else if (!input_gone && gone_cnt == 16'(DGL - 1)) begin
            input_gone <= 1'b1;
            input_undervoltage_evt   <= 1'b1;  // R21
        end else begin
            input_undervoltage_evt <= 1'b0;
            if (!input_gone) begin
                gone_cnt <= gone_cnt + 16'h0001;
            end
        end
    end

    // Overvoltage onset immediate, release after deglitch
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ovp_cnt <= 16'h0000;
            ovp_act <= 1'b0;
            ovp_evt <= 1'b0;
        end else if (cmp.vin_ovp) begin
            ovp_cnt <= 16'h0000;
            ovp_act <= 1'b1;
            ovp_evt <= ~ovp_act;  // R19
        end else begin
            ovp_evt <= 1'b0;
            if (ovp_act && ovp_cnt == 16'(DGL - 1)) begin
                ovp_act <= 1'b0;  // R19
                ovp_cnt <= 16'h0000;
            end else if (ovp_act) begin
                ovp_cnt <= ovp_cnt + 16'h0001;
            end
        end
    end

    // Mode selection
    always_comb begin
        next_mode = mode;
        if (ovp_act) begin
            next_mode = M_OVP;
        end else if (input_gone) begin
            case (mode)
                M_HIZ: begin
                    next_mode = cmp.charge_inhibit_pin_n ? M_ACTBAT : M_HIZ;  // R8
                end
                M_MEAS: begin
                    if (cmp.charge_inhibit_pin_n) begin
                        next_mode = M_ACTBAT;
                    end else if (meas_done) begin
                        next_mode = M_HIZ;  // R11
                    end
                end
                default: begin
                    next_mode = cmp.charge_inhibit_pin_n ? M_ACTBAT : M_MEAS;  // R8 R11
                end
            endcase
        end else if (!cmp.vin_above_sleep) begin
            next_mode = M_SLEEP;  // R14
        end else if (!charge_go) begin
            next_mode = M_IDLE;  // R8 R22
        end else if (mode == M_DONE || (mode == M_CHARGE && term_hit)) begin
            next_mode = M_DONE;  // R23
        end else begin
            next_mode = M_CHARGE;  // R9 R15
        end
    end

    // Mode register
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            mode <= M_HIZ;
        end else begin
            mode <= next_mode;
        end
    end

    // Switch drives from mode
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            disch_on_out         <= 1'b0;
            supplement_on_out    <= 1'b0;
            charge_switch_on_out <= 1'b0;
        end else begin
            case (mode)
                M_ACTBAT: begin
                    disch_on_out         <= bat_ok & ~sc_off;  // R1 R5 R6
                    supplement_on_out    <= 1'b0;
                    charge_switch_on_out <= 1'b0;
                end
                M_SLEEP, M_OVP: begin
                    disch_on_out         <= ~sc_off;  // R14 R19
                    supplement_on_out    <= 1'b0;
                    charge_switch_on_out <= 1'b0;
                end
                M_CHARGE: begin
                    disch_on_out         <= cmp.bat_above_min & ~sc_off;  // R7
                    supplement_on_out    <= cmp.bat_above_min;            // R7
                    charge_switch_on_out <= 1'b1;
                end
                M_DONE: begin
                    disch_on_out         <= cmp.bat_above_min & ~sc_off;  // R7
                    supplement_on_out    <= cmp.bat_above_min;            // R7
                    charge_switch_on_out <= 1'b0;  // R23
                end
                default: begin
                    // Idle, high impedance, measuring: path open
                    disch_on_out         <= 1'b0;  // R22
                    supplement_on_out    <= 1'b0;
                    charge_switch_on_out <= 1'b0;
                end
            endcase
        end
    end

    // System rail comes up after the battery deglitch in battery-only mode
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rail_cnt        <= 16'h0000;
            rail_enable_out <= 1'b0;
        end else if (mode != M_ACTBAT || !bat_ok) begin
            rail_cnt        <= 16'h0000;
            rail_enable_out <= (mode != M_HIZ) && (mode != M_MEAS) && (mode != M_ACTBAT);
        end else if (rail_cnt == 16'(DGL - 1)) begin
            rail_enable_out <= 1'b1;  // R6
        end else begin
            rail_cnt <= rail_cnt + 16'h0001;
        end
    end

    // Host interfaces ready after the rail settles
    always_ff @(posedge core_clk_in) begin
        if (reset_in || !cmp.rail_ok) begin
            rdy_cnt        <= 28'h0000000;
            host_ready_out <= 1'b0;
        end else if (!host_ready_out) begin
            if (rdy_cnt == 28'(READY - 1)) begin
                host_ready_out <= 1'b1;  // R10
            end else begin
                rdy_cnt <= rdy_cnt + 28'h0000001;
            end
        end
    end

    // Battery level measurement window and latch
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            meas_busy                  <= 1'b0;
            meas_cnt                   <= 28'h0000000;
            level_threshold_result_out <= LVL_RESET;
        end else if (meas_busy) begin
            if (meas_done) begin
                meas_busy                  <= 1'b0;
                meas_cnt                   <= 28'h0000000;
                level_threshold_result_out <= tap_code(cmp.level_taps);  // R13
            end else begin
                meas_cnt <= meas_cnt + 28'h0000001;
            end
        end else if (level_sample_trigger_in || mode == M_MEAS) begin
            meas_busy <= 1'b1;  // R11 R12
        end
    end

    // Sleep fault: needs a read and the end of sleep
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            fault_out.sleep <= 1'b0;
            sleep_seen      <= 1'b0;
        end else if (sleep_evt) begin
            fault_out.sleep <= 1'b1;  // R14
            sleep_seen      <= 1'b0;
        end else if (fault_out.sleep) begin
            if (sleep_seen && mode != M_SLEEP) begin
                fault_out.sleep <= 1'b0;  // R16
                sleep_seen      <= 1'b0;
            end else if (fault_read_in) begin
                sleep_seen <= 1'b1;
            end
        end
    end

    // Overvoltage and undervoltage faults clear on a read after the end
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            fault_out.input_overvoltage  <= 1'b0;
            fault_out.input_undervoltage <= 1'b0;
        end else begin
            if (ovp_evt) begin
                fault_out.input_overvoltage <= 1'b1;
            end else if (fault_read_in && !ovp_act) begin
                fault_out.input_overvoltage <= 1'b0;  // R20
            end
            if (input_undervoltage_evt) begin
                fault_out.input_undervoltage <= 1'b1;
            end else if (fault_read_in && !input_gone) begin
                fault_out.input_undervoltage <= 1'b0;  // R21
            end
        end
    end

    // Status and setting outputs
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            mode_out             <= M_HIZ;
            input_droop_flag_out <= 1'b0;
            timer_half_speed_out <= 1'b0;
            floor_mv_out         <= FLOOR_BASE_MV;
            rearm_mv_out         <= REARM_HYST_MV;
            level_busy_out       <= 1'b0;
        end else begin
            mode_out             <= mode;
            input_droop_flag_out <= droop;                    // R18
            timer_half_speed_out <= double_timer_in & droop;  // R18
            floor_mv_out         <= FLOOR_BASE_MV + 13'(FLOOR_STEP_MV * input_voltage_floor_in);  // R17
            rearm_mv_out         <= battery_low_cutoff_in + REARM_HYST_MV;  // R5
            level_busy_out       <= meas_busy;
        end
    end

    // Open drain: pull low only during a pulse
    assign event_o_out  = 1'b0;
    assign event_oe_out = ev_busy;

    a_sc_off_path: assert property (sc_off |=> !disch_on_out)  // R1
        else $error("path on during short recovery");
    a_sc_recover_time: assert property ($fell(sc_off) |-> $past(sc_cnt) == 28'(SC_REC - 1))  // R2
        else $error("short recovery time wrong");
    a_cutoff_open: assert property ((mode == M_ACTBAT && !bat_ok) |=> !disch_on_out)  // R5
        else $error("path on below cutoff");
    a_hiz_measured: assert property ((mode != M_HIZ && next_mode == M_HIZ) |-> meas_done)  // R11
        else $error("high impedance without measurement");
    a_meas_window: assert property ($rose(meas_busy) |-> meas_busy [*8])  // R12
        else $error("measurement ended early");
    a_droop_no_term: assert property ((droop && mode == M_CHARGE) |=> mode != M_DONE)  // R18
        else $error("termination during floor limiting");
    a_inhibit_idle: assert property ((cmp.charge_inhibit_pin_n && !ovp_act && !input_gone
        && cmp.vin_above_sleep) |=> mode == M_IDLE)  // R8
        else $error("charging despite inhibit pin");
    a_sleep_hold: assert property ((fault_out.sleep && mode == M_SLEEP) |=> fault_out.sleep)  // R16
        else $error("sleep fault cleared in sleep");
    a_ovp_hold: assert property ((fault_out.input_overvoltage && ovp_act) |=> fault_out.input_overvoltage)  // R20
        else $error("overvoltage fault cleared early");
    a_ready_time: assert property ($rose(host_ready_out) |-> $past(rdy_cnt) == 28'(READY - 1))  // R10
        else $error("host ready time wrong");
endmodule // cmf_top

// [sim/cmf_host.sv]
// Purpose: Host side model issuing fault read and sample trigger pulses
// Assumes: Requests arrive from the bench as levels
// Notes:   Each request level is copied unchanged to its output at the falling edge
`timescale 1ns/1ps
module cmf_host (
    // Clock
    input  wire logic core_clk_in,
    // Requests from the bench
    input  wire logic rd_req_in,
    input  wire logic tr_req_in,
    // Pulses to the block
    output logic      fault_read_out = 1'b0,
    output logic      trigger_out    = 1'b0
);
    // Host copies the fault read and sample trigger requests to its outputs at each falling edge
    always @(negedge core_clk_in) begin
        fault_read_out <= rd_req_in;
        trigger_out    <= tr_req_in;
    end
endmodule // cmf_host

// [sim/tb.sv]
// Purpose: Self-checking bench of the charger mode and fault supervisor
// Assumes: Shortened counts, inputs driven at the falling edge
// Notes:   Expected values come from the parameters set here
`timescale 1ns/1ps
module tb;
    import cmf_pkg::*;
    logic clk = 0, rst = 1, ce_n = 0, rd = 0, tr = 0, frd, trg, dis, chg, oe, busy;
    logic te = 0, dt = 0, fd = 0, rdy, drp, hs;
    logic [2:0] code = 0;
    logic [12:0] cut = 13'h0bb8, flr, rea;
    logic [4:0] lvl;
    cmf_cmp_s c = '0;
    cmf_mode_e mode;
    cmf_fault_s flt;
    int n_fail = 0, check_count = 0, i, w;
    cmf_host i_host (.core_clk_in(clk), .rd_req_in(rd), .tr_req_in(tr), .fault_read_out(frd), .trigger_out(trg));
    cmf_top #(.SC_DGL(20), .SC_REC(40), .PULSE(10), .READY(30), .MEAS(16), .DGL(8)) i_dut (
        .core_clk_in(clk), .reset_in(rst), .cmp_in(c), .charge_enable_n_in(ce_n), .term_enable_in(te),
        .double_timer_in(dt), .input_voltage_floor_in(code), .floor_disable_in(fd),
        .battery_low_cutoff_in(cut), .level_sample_trigger_in(trg), .fault_read_in(frd),
        .disch_on_out(dis), .supplement_on_out(), .charge_switch_on_out(chg), .rail_enable_out(),
        .floor_mv_out(flr), .rearm_mv_out(rea), .mode_out(mode), .fault_out(flt), .input_droop_flag_out(drp),
        .timer_half_speed_out(hs), .level_threshold_result_out(lvl), .level_busy_out(busy),
        .host_ready_out(rdy), .event_o_out(), .event_oe_out(oe));
    // Clock of 10 ns
    initial forever #5 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic end_sim;
        $display("checks=%0d fails=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Floor codes and rearm level
    task automatic t_floor;
        for (int k = 0; k < 8; k++) begin
            code = 3'(k);
            cyc(3);
            chk(16'(flr), 16'(4200 + 100 * k));
        end
        chk(16'(rea), 16'(cut) + 16'd150);
        $display("floor done");
    endtask
    // Charging, sleep entry with pulse, fault hold and exit
    task automatic t_sleep;
        c = '0;
        {c.vin_input_undervoltage_ok, c.vin_above_sleep, c.bat_above_cutoff, c.bat_above_rearm, c.bat_above_min} = 5'h1f;
        c.rail_ok = 1;
        cyc(12);
        chk(16'(mode), 16'(M_CHARGE));
        chk(16'(rdy), 16'h0);
        ce_n = 1;
        cyc(10);
        chk(16'(chg), 16'h0);
        ce_n = 0;
        cyc(10);
        chk(16'(chg), 16'h1);
        c.vin_above_sleep = 0;
        for (i = 0; i < 30 && oe !== 1'b1; i++) cyc(1);
        for (w = 0; w < 40 && oe === 1'b1; w++) cyc(1);
        chk(16'(w), 16'd10);
        chk(16'(flt.sleep), 16'h1);
        chk(16'(dis), 16'h1);
        chk(16'(rdy), 16'h1);
        rd <= 1'b1;
        cyc(1);
        rd <= 1'b0;
        cyc(4);
        chk(16'(flt.sleep), 16'h1);
        c.vin_above_sleep = 1;
        cyc(12);
        chk(16'(mode), 16'(M_CHARGE));
        chk(16'(flt.sleep), 16'h0);
        $display("sleep done");
    endtask
    // Overvoltage, floor limit and termination
    task automatic t_term;
        c.vin_ovp = 1;
        cyc(8);
        chk(16'(mode), 16'(M_OVP));
        chk(16'(flt.input_overvoltage), 16'h1);
        c.vin_ovp = 0;
        cyc(16);
        rd <= 1'b1;
        cyc(1);
        rd <= 1'b0;
        cyc(4);
        chk(16'(flt.input_overvoltage), 16'h0);
        {c.vin_at_floor, c.other_loop, c.cv_loop, c.taper_reached, c.bat_above_recharge} = 5'h1f;
        {te, dt} = 2'h3;
        cyc(8);
        chk(16'({drp, hs}), 16'h3);
        c.vin_at_floor = 0;
        cyc(8);
        chk(16'(mode), 16'(M_CHARGE));
        c.other_loop = 0;
        cyc(8);
        chk(16'(mode), 16'(M_DONE));
        {c.vin_at_floor, fd} = 2'h3;
        cyc(8);
        chk(16'(drp), 16'h0);
        c.charge_inhibit_pin_n = 1;
        cyc(8);
        chk(16'(mode), 16'(M_IDLE));
        $display("term done");
    endtask
    // Battery only with a short: off, recovery, retry
    task automatic t_short;
        c.vin_input_undervoltage_ok = 0;
        c.vin_above_sleep = 0;
        c.charge_inhibit_pin_n = 1;
        cyc(25);
        chk(16'(mode), 16'(M_ACTBAT));
        chk(16'(dis), 16'h1);
        c.short_hit = 1;
        for (i = 0; i < 40 && dis === 1'b1; i++) cyc(1);
        chk(16'(i >= 20), 16'h1);
        for (w = 0; w < 80 && dis !== 1'b1; w++) cyc(1);
        chk(16'(w >= 38 && w <= 44), 16'h1);
        for (i = 0; i < 40 && dis === 1'b1; i++) cyc(1);
        chk(16'(dis), 16'h0);
        c.short_hit = 0;
        $display("short done");
    endtask
    // Level samples at empty, one third, two thirds and full tap counts
    task automatic t_meas;
        for (int k = 0; k <= 21; k += 7) begin
            c.level_taps = 21'((64'h1 << k) - 1);
            tr <= 1'b1;
            cyc(1);
            tr <= 1'b0;
            for (i = 0; i < 10 && busy !== 1'b1; i++) cyc(1);
            for (i = 0; i < 40 && busy === 1'b1; i++) cyc(1);
            chk(16'(lvl), 16'(k));
        end
        c.charge_inhibit_pin_n = 0;
        c.level_taps = 21'h000001;
        cyc(30);
        chk(16'(mode), 16'(M_HIZ));
        chk(16'(lvl), 16'h1);
        $display("sample done");
    endtask
    initial begin
        cyc(2);
        chk(16'(mode), 16'(M_HIZ));
        rst = 0;
        t_floor();
        t_sleep();
        t_term();
        t_short();
        t_meas();
        end_sim();
    end
    // Watchdog against a hang
    initial begin
        #100000;
        n_fail++;
        end_sim();
    end
endmodule // tb
